/* File: hw/pwr_key_pkg.sv */
/*
 * Shared constants and carrier types for the power key and reset request block.
 * Assumes a single 100 MHz clock and a synchronous active-low reset.
 */
package pwr_key_pkg;

    // key function encodings
    localparam logic [1:0] FUNC_PLAIN = 2'h0;
    localparam logic [1:0] FUNC_LOCK = 2'h1;
    localparam logic [1:0] FUNC_OFF = 2'h2;
    localparam logic [1:0] FUNC_STANDBY = 2'h3;

    // debounce time selections in microseconds, picked by a 2-bit field
    localparam int DEB_US_0 = 0;
    localparam int DEB_US_1 = 100;
    localparam int DEB_US_2 = 1000;
    localparam int DEB_US_3 = 10000;
    localparam int CLK_MHZ = 100;
    localparam int DEB_CYC_1 = DEB_US_1 * CLK_MHZ;
    localparam int DEB_CYC_2 = DEB_US_2 * CLK_MHZ;
    localparam int DEB_CYC_3 = DEB_US_3 * CLK_MHZ;
    localparam int DEB_W = 20;

    // long-press delay: 4-bit field, each step is one period in milliseconds
    localparam int KEY_STEP_MS = 1;
    localparam int KEY_STEP_CYC = KEY_STEP_MS * 1000 * CLK_MHZ;
    localparam int KEY_STEP_W = 17;

    // reset-request delay before the sequencer is told to go to reset
    localparam int RST_SEQ_US = 100;
    localparam int RST_FAST_US = 10;
    localparam int RST_SEQ_CYC = RST_SEQ_US * CLK_MHZ;
    localparam int RST_FAST_CYC = RST_FAST_US * CLK_MHZ;
    localparam int RST_W = 14;

    // reset values
    localparam logic RUN_RST = 1'b1;
    localparam logic STANDBY_RST = 1'b0;

    // configuration from software
    typedef struct packed {
        logic [1:0] debounce_sel;
        logic [1:0] key_function_field;
        logic [3:0] long_press_steps;
        logic power_key_event_mask;
        logic fast_shutdown_sel;
    } key_cfg_s;

    // one-cycle software clear/set strobes
    typedef struct packed {
        logic clr_key_event;
        logic clr_lock;
        logic clr_reset_fault;
        logic set_run;
        logic clr_run;
        logic set_standby;
        logic clr_standby;
    } key_cmd_s;

    // status visible to software
    typedef struct packed {
        logic power_key_level;
        logic power_key_event;
        logic long_press_lock_flag;
        logic reset_request_fault;
    } key_status_s;

endpackage

/* File: hw/in_debounce.sv */
/*
 * Synchroniser and debounce filter for one active-low pin.
 * Assumes an asynchronous pin and a shared debounce limit from the parent.
 */
`timescale 1ns/100ps
module in_debounce (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic pin_i,
    input wire logic [pwr_key_pkg::DEB_W-1:0] limit_i,
    output logic level_o
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;
    logic [pwr_key_pkg::DEB_W-1:0] cnt_q;

    // three-stage sync; pins idle high so reset to one
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else if (clk_en_i) begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // accept a new level only after it held for the limit; glitches restart
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
            level_q <= 1'b1;
        end else if (clk_en_i) begin
            if (s2_q != s3_q || s3_q == level_q) begin
                cnt_q <= '0;
            end else if (cnt_q >= limit_i) begin
                level_q <= s3_q;
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    assign level_o = level_q;
endmodule // in_debounce

/* File: hw/press_timer.sv */
/*
 * Long-press timer: counts step ticks while held, fires once per press.
 * Assumes a debounced active-high press level on the same clock.
 */
`timescale 1ns/100ps
module press_timer (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic pressed_i,
    input wire logic [3:0] steps_i,
    output logic fire_o,
    output logic long_o
);
    logic [pwr_key_pkg::KEY_STEP_W-1:0] tick_q;
    logic [3:0] steps_q;
    logic long_q;
    logic fire_q;
    logic step_done;

    assign step_done = (tick_q == pwr_key_pkg::KEY_STEP_W'(pwr_key_pkg::KEY_STEP_CYC - 1));

    // cleared on release so every press starts from zero
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            tick_q <= '0;
            steps_q <= '0;
            long_q <= 1'b0;
            fire_q <= 1'b0;
        end else if (clk_en_i) begin
            fire_q <= 1'b0;
            if (!pressed_i) begin
                tick_q <= '0;
                steps_q <= '0;
                long_q <= 1'b0;
            end else if (!long_q) begin
                if (steps_q >= steps_i) begin
                    long_q <= 1'b1; // latch stops a second fire
                    fire_q <= 1'b1;
                end else if (step_done) begin
                    tick_q <= '0;
                    steps_q <= steps_q + 1'b1;
                end else begin
                    tick_q <= tick_q + 1'b1;
                end
            end
        end
    end

    assign fire_o = fire_q;
    assign long_o = long_q;
endmodule // press_timer

/* File: hw/power_key_and_reset_request.sv */
/*
 * Power key and reset request control logic.
 * Assumes a power sequencer that acts on run/standby/reset requests and
 * reports power-down state; software drives config and one-cycle commands.
 */
`timescale 1ns/100ps
module power_key_and_reset_request (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic power_key_n_i,
    input wire logic host_reset_request_n_i,
    input wire logic power_down_state_i,
    input wire pwr_key_pkg::key_cfg_s cfg_i,
    input wire pwr_key_pkg::key_cmd_s cmd_i,
    output pwr_key_pkg::key_status_s status_o,
    output logic system_run_o,
    output logic standby_o,
    output logic wakeup_o,
    output logic reset_mode_req_o,
    output logic host_reset_n_o,
    output logic interrupt_out_n_o
);
    logic [pwr_key_pkg::DEB_W-1:0] deb_limit;
    logic key_lvl;
    logic req_lvl;
    logic key_prev_q;
    logic press;
    logic release_ev;
    logic fire;
    logic long_now;
    logic short_rel;
    logic key_event_q;
    logic lock_q;
    logic fault_q;
    logic run_q;
    logic standby_q;
    logic wake_q;
    logic irq_n_q;
    logic level_q;
    logic key_raise;

    typedef enum logic [1:0] {RST_IDLE, RST_WAIT, RST_HELD} rst_state_e;
    rst_state_e rst_state_q;
    logic [pwr_key_pkg::RST_W-1:0] rst_cnt_q;
    logic reset_req_q;
    logic host_rst_n_q;

    // one shared debounce time for all inputs
    always_comb begin
        case (cfg_i.debounce_sel)
            2'h0: deb_limit = pwr_key_pkg::DEB_W'(pwr_key_pkg::DEB_US_0);
            2'h1: deb_limit = pwr_key_pkg::DEB_W'(pwr_key_pkg::DEB_CYC_1);
            2'h2: deb_limit = pwr_key_pkg::DEB_W'(pwr_key_pkg::DEB_CYC_2);
            default: deb_limit = pwr_key_pkg::DEB_W'(pwr_key_pkg::DEB_CYC_3);
        endcase
    end

    in_debounce key_deb (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .clk_en_i(clk_en_i),
        .pin_i(power_key_n_i),
        .limit_i(deb_limit),
        .level_o(key_lvl)
    );

    in_debounce req_deb (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .clk_en_i(clk_en_i),
        .pin_i(host_reset_request_n_i),
        .limit_i(deb_limit),
        .level_o(req_lvl)
    );

    // edge detection on the debounced key, never gated by power mode
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            key_prev_q <= 1'b1;
            level_q <= 1'b0;
        end else if (clk_en_i) begin
            key_prev_q <= key_lvl;
            level_q <= ~key_lvl; // status shows pressed as one
        end
    end

    assign press = key_prev_q & ~key_lvl;
    assign release_ev = ~key_prev_q & key_lvl;

    press_timer key_tmr (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .clk_en_i(clk_en_i),
        .pressed_i(~key_lvl),
        .steps_i(cfg_i.long_press_steps),
        .fire_o(fire),
        .long_o(long_now)
    );

    // short release: the timer had not fired for this press
    assign short_rel = release_ev & ~long_now;

    // event raise per function
    always_comb begin
        if (cfg_i.key_function_field == pwr_key_pkg::FUNC_PLAIN) begin
            key_raise = press;
        end else begin
            key_raise = short_rel | fire;
        end
    end

    // key event flag: sticky, set beats clear
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            key_event_q <= 1'b0;
        end else if (clk_en_i) begin
            if (key_raise) begin
                key_event_q <= 1'b1;
            end else if (cmd_i.clr_key_event) begin
                key_event_q <= 1'b0;
            end
        end
    end

    // long-press lock: any non-plain function sets it on timer fire
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            lock_q <= 1'b0;
        end else if (clk_en_i) begin
            if (fire && cfg_i.key_function_field != pwr_key_pkg::FUNC_PLAIN) begin
                lock_q <= 1'b1;
            end else if (cmd_i.clr_lock) begin
                lock_q <= 1'b0; // host clears before power-down
            end
        end
    end

    // run and standby requests; hardware actions win over software writes
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            run_q <= pwr_key_pkg::RUN_RST;
            standby_q <= pwr_key_pkg::STANDBY_RST;
        end else if (clk_en_i) begin
            if (fire && cfg_i.key_function_field == pwr_key_pkg::FUNC_OFF) begin
                run_q <= 1'b0;
                standby_q <= standby_q;
            end else if (fire && cfg_i.key_function_field == pwr_key_pkg::FUNC_STANDBY) begin
                run_q <= 1'b0;
                standby_q <= 1'b0;
            end else if (short_rel && cfg_i.key_function_field == pwr_key_pkg::FUNC_STANDBY) begin
                run_q <= 1'b0;
                standby_q <= 1'b1;
            end else begin
                if (cmd_i.set_run) begin
                    run_q <= 1'b1;
                end else if (cmd_i.clr_run) begin
                    run_q <= 1'b0;
                end
                if (cmd_i.set_standby) begin
                    standby_q <= 1'b1;
                end else if (cmd_i.clr_standby) begin
                    standby_q <= 1'b0;
                end
            end
        end
    end

    // wakeup pulse, only in power-down, suppressed by the mask
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            wake_q <= 1'b0;
        end else if (clk_en_i) begin
            wake_q <= 1'b0;
            if (power_down_state_i && !cfg_i.power_key_event_mask) begin
                if (lock_q) begin
                    wake_q <= fire; // only a long press wakes while locked
                end else begin
                    wake_q <= key_raise;
                end
            end
        end
    end

    // reset request: fault and host reset first, then ask the sequencer
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rst_state_q <= RST_IDLE;
            rst_cnt_q <= '0;
            reset_req_q <= 1'b0;
            host_rst_n_q <= 1'b1;
        end else if (clk_en_i) begin
            case (rst_state_q)
                RST_IDLE: begin
                    reset_req_q <= 1'b0;
                    host_rst_n_q <= 1'b1;
                    if (!req_lvl) begin
                        host_rst_n_q <= 1'b0; // asserted before reset mode
                        rst_cnt_q <= cfg_i.fast_shutdown_sel ?
                            pwr_key_pkg::RST_W'(pwr_key_pkg::RST_FAST_CYC) :
                            pwr_key_pkg::RST_W'(pwr_key_pkg::RST_SEQ_CYC);
                        rst_state_q <= RST_WAIT;
                    end
                end
                RST_WAIT: begin
                    if (rst_cnt_q == '0) begin
                        reset_req_q <= 1'b1;
                        rst_state_q <= RST_HELD;
                    end else begin
                        rst_cnt_q <= rst_cnt_q - 1'b1;
                    end
                end
                RST_HELD: begin
                    // held until the request pin releases; RST_IDLE then drops the mode request and releases host reset
                    if (req_lvl) begin
                        rst_state_q <= RST_IDLE;
                    end
                end
                default: rst_state_q <= RST_IDLE;
            endcase
        end
    end

    // fault log bit: set on request entry, beats software clear
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            fault_q <= 1'b0;
        end else if (clk_en_i) begin
            if (rst_state_q == RST_IDLE && !req_lvl) begin
                fault_q <= 1'b1;
            end else if (cmd_i.clr_reset_fault) begin
                fault_q <= 1'b0;
            end
        end
    end

    // interrupt follows the pending unmasked key event, low active
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            irq_n_q <= 1'b1;
        end else if (clk_en_i) begin
            irq_n_q <= ~(key_event_q & ~cfg_i.power_key_event_mask);
        end
    end

    assign status_o.power_key_level = level_q;
    assign status_o.power_key_event = key_event_q;
    assign status_o.long_press_lock_flag = lock_q;
    assign status_o.reset_request_fault = fault_q;
    assign system_run_o = run_q;
    assign standby_o = standby_q;
    assign wakeup_o = wake_q;
    assign reset_mode_req_o = reset_req_q;
    assign host_reset_n_o = host_rst_n_q;
    assign interrupt_out_n_o = irq_n_q;
endmodule // power_key_and_reset_request

/* File: dv/key_host_model.sv */
/*
 * Far-side model: a push-button power key and a host reset request line.
 * Assumes the bench moves press_i and request_i just after a falling edge.
 */
`timescale 1ns/100ps
module key_host_model (
    input wire logic press_i,
    input wire logic request_i,
    output logic power_key_n_o,
    output logic host_reset_request_n_o
);
    // both pins idle high on pull-ups, a closed contact pulls them low
    assign power_key_n_o = !press_i;
    assign host_reset_request_n_o = !request_i;
endmodule // key_host_model

/* File: dv/pkr_checker.sv */
/*
 * Concurrent checks on the power key and reset request block ports.
 * Assumes clk_en_i stays high, so every edge advances the block.
 */
`timescale 1ns/100ps
module pkr_checker (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic power_down_state_i,
    input wire pwr_key_pkg::key_cfg_s cfg_i,
    input wire pwr_key_pkg::key_cmd_s cmd_i,
    input wire pwr_key_pkg::key_status_s status_o,
    input wire logic system_run_o,
    input wire logic wakeup_o,
    input wire logic reset_mode_req_o,
    input wire logic host_reset_n_o,
    input wire logic interrupt_out_n_o
);
    int unsigned low_q;

    // cycles spent with host reset held low, the base of the mode delay
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || host_reset_n_o) low_q <= 0;
        else low_q <= low_q + 1;
    end

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_press_evt;
        $rose(status_o.power_key_event) ##0
            cfg_i.key_function_field == pwr_key_pkg::FUNC_PLAIN;
    endsequence
    sequence s_off_lock;
        cfg_i.key_function_field == pwr_key_pkg::FUNC_OFF ##0
            $rose(status_o.long_press_lock_flag);
    endsequence

    property p_irq;
        interrupt_out_n_o ==
            !($past(status_o.power_key_event) && !$past(cfg_i.power_key_event_mask));
    endproperty
    property p_wake_cause;
        wakeup_o |-> $past(power_down_state_i) && !$past(cfg_i.power_key_event_mask);
    endproperty
    property p_wake_pulse;
        wakeup_o |=> !wakeup_o;
    endproperty
    property p_ev_hold;
        status_o.power_key_event && !cmd_i.clr_key_event |=> status_o.power_key_event;
    endproperty
    property p_lock_hold;
        status_o.long_press_lock_flag && !cmd_i.clr_lock |=> status_o.long_press_lock_flag;
    endproperty
    property p_lock_fn;
        $rose(status_o.long_press_lock_flag) |->
            cfg_i.key_function_field != pwr_key_pkg::FUNC_PLAIN;
    endproperty
    property p_press_ev;
        s_press_evt |-> status_o.power_key_level;
    endproperty
    property p_off;
        s_off_lock |-> ##[0:1] !system_run_o;
    endproperty
    property p_hrst;
        $fell(host_reset_n_o) |-> status_o.reset_request_fault;
    endproperty
    // the window is kept narrow so a wrong delay constant cannot slip by
    property p_mode_delay;
        $rose(reset_mode_req_o) |-> !host_reset_n_o && low_q + 2 >=
            (cfg_i.fast_shutdown_sel ? pwr_key_pkg::RST_FAST_CYC : pwr_key_pkg::RST_SEQ_CYC)
            && low_q <= 2 +
            (cfg_i.fast_shutdown_sel ? pwr_key_pkg::RST_FAST_CYC : pwr_key_pkg::RST_SEQ_CYC);
    endproperty

    a_irq: assert property (p_irq) else $error("interrupt not tied to event");
    a_wake_cause: assert property (p_wake_cause) else $error("bad wakeup");
    a_wake_pulse: assert property (p_wake_pulse) else $error("wakeup too long");
    a_ev_hold: assert property (p_ev_hold) else $error("event dropped");
    a_lock_hold: assert property (p_lock_hold) else $error("lock dropped");
    a_lock_fn: assert property (p_lock_fn) else $error("lock in plain mode");
    a_press_ev: assert property (p_press_ev) else $error("event without press");
    a_off: assert property (p_off) else $error("run kept on long press");
    a_hrst: assert property (p_hrst) else $error("host reset without fault");
    a_mode_delay: assert property (p_mode_delay) else $error("reset mode timing");
endmodule // pkr_checker

bind power_key_and_reset_request pkr_checker u_chk (.ref_clk_i, .rst_n_i,
    .power_down_state_i, .cfg_i, .cmd_i, .status_o, .system_run_o, .wakeup_o,
    .reset_mode_req_o, .host_reset_n_o, .interrupt_out_n_o);

/* File: dv/tb.sv */
/*
 * Self-checking bench for the power key and reset request block.
 * Assumes debounce_sel 0 so pin changes land within a few cycles.
 */
`timescale 1ns/100ps
module tb;
    logic ref_clk_i, rst_n_i, pd, press, req, key_n, req_n;
    logic run, stby, wake, rmode, hrst_n, irq_n, en;
    pwr_key_pkg::key_cfg_s cfg;
    pwr_key_pkg::key_cmd_s cmd;
    pwr_key_pkg::key_status_s st;
    int mismatches, checks, cyc, wakes;

    key_host_model u_key (.press_i(press), .request_i(req), .power_key_n_o(key_n),
        .host_reset_request_n_o(req_n));
    power_key_and_reset_request u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .clk_en_i(en), .power_key_n_i(key_n), .host_reset_request_n_i(req_n),
        .power_down_state_i(pd), .cfg_i(cfg), .cmd_i(cmd), .status_o(st),
        .system_run_o(run), .standby_o(stby), .wakeup_o(wake),
        .reset_mode_req_o(rmode), .host_reset_n_o(hrst_n), .interrupt_out_n_o(irq_n));

    // clock at 100 MHz
    initial begin
        ref_clk_i = 1'h0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    // cycle ceiling and wakeup pulse count
    always @(posedge ref_clk_i) begin
        cyc++;
        if (wake === 1'h1) wakes++;
        if (cyc == 60000) begin
            mismatches++;
            results();
        end
    end

    task results();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task chk(input string n, input logic [15:0] e, input logic [15:0] s);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %0h seen %0h", n, e, s);
        end
    endtask

    task pulse(input pwr_key_pkg::key_cmd_s c);
        @(negedge ref_clk_i);
        cmd = c;
        @(negedge ref_clk_i);
        cmd = '0;
    endtask

    task key(input logic v, input int n);
        @(negedge ref_clk_i);
        press = v;
        repeat (n) @(negedge ref_clk_i);
    endtask

    // the clear pulse leaves flags from earlier tests out of each result
    task setup(input logic [1:0] fn, input logic [3:0] steps, input logic mask,
        input pwr_key_pkg::key_cmd_s c);
        cfg.key_function_field = fn;
        cfg.long_press_steps = steps;
        cfg.power_key_event_mask = mask;
        pulse(c);
        wakes = 0;
    endtask

    task t_plain();
        pd = 1'h1;
        setup(pwr_key_pkg::FUNC_PLAIN, 4'h0, 1'h0, 7'h69);
        key(1'h1, 8);
        chk("event", 1, st.power_key_event);
        chk("level pressed", 1, st.power_key_level);
        chk("irq", 0, irq_n);
        chk("wakeups", 1, wakes);
        key(1'h0, 8);
        chk("level released", 0, st.power_key_level);
        chk("irq held", 0, irq_n);
        pulse(7'h40);
        @(negedge ref_clk_i);
        chk("irq cleared", 1, irq_n);
        $display("done plain press");
    endtask

    task t_mask();
        setup(pwr_key_pkg::FUNC_PLAIN, 4'h0, 1'h1, 7'h69);
        key(1'h1, 8);
        chk("masked event", 1, st.power_key_event);
        chk("masked irq", 1, irq_n);
        chk("masked wakeups", 0, wakes);
        key(1'h0, 8);
        pd = 1'h0;
        $display("done mask");
    endtask

    // a short touch under a long debounce, then a frozen clock enable
    task t_glitch();
        cfg.debounce_sel = 2'h1;
        key(1'h1, 50);
        chk("glitch refused", 0, st.power_key_level);
        key(1'h0, 8);
        cfg.debounce_sel = 2'h0;
        en = 1'h0;
        key(1'h1, 10);
        chk("frozen level", 0, st.power_key_level);
        en = 1'h1;
        repeat (8) @(negedge ref_clk_i);
        chk("thawed level", 1, st.power_key_level);
        key(1'h0, 8);
        $display("done glitch and enable");
    endtask

    task t_short();
        setup(pwr_key_pkg::FUNC_STANDBY, 4'h1, 1'h0, 7'h69);
        key(1'h1, 40);
        chk("no event held", 0, st.power_key_event);
        key(1'h0, 8);
        chk("release event", 1, st.power_key_event);
        chk("run short", 0, run);
        chk("standby short", 1, stby);
        chk("no lock", 0, st.long_press_lock_flag);
        $display("done short press");
    endtask

    // every long-press function, with a standby request already raised
    task t_long();
        for (int f = 1; f < 4; f++) begin
            setup(f[1:0], 4'h0, 1'h0, 7'h6a);
            key(1'h1, 12);
            chk("long event", 1, st.power_key_event);
            chk("long lock", 1, st.long_press_lock_flag);
            chk("long run", f == 1, run);
            chk("long standby", f < 3, stby);
            pulse(7'h40);
            key(1'h0, 8);
            chk("one fire only", 0, st.power_key_event);
            chk("lock kept", 1, st.long_press_lock_flag);
        end
        $display("done long press");
    endtask

    task t_lock_wake();
        pd = 1'h1;
        setup(pwr_key_pkg::FUNC_LOCK, 4'h0, 1'h0, 7'h69);
        key(1'h1, 12);
        key(1'h0, 8);
        cfg.long_press_steps = 4'h1;
        wakes = 0;
        key(1'h1, 20);
        key(1'h0, 10);
        chk("locked wakeups", 0, wakes);
        cfg.long_press_steps = 4'h0;
        wakes = 0;
        key(1'h1, 12);
        key(1'h0, 8);
        chk("locked long wakeup", 1, wakes);
        cfg.long_press_steps = 4'h1;
        pulse(7'h20);
        wakes = 0;
        key(1'h1, 20);
        key(1'h0, 10);
        chk("unlocked wakeup", 1, wakes != 0);
        pd = 1'h0;
        $display("done lock wakeup");
    endtask

    task t_reset();
        int n;
        int d;
        for (int f = 0; f < 2; f++) begin
            cfg.fast_shutdown_sel = f[0];
            d = f ? pwr_key_pkg::RST_FAST_CYC : pwr_key_pkg::RST_SEQ_CYC;
            @(negedge ref_clk_i);
            req = 1'h1;
            for (n = 0; hrst_n !== 1'h0 && n < 20; n++) @(negedge ref_clk_i);
            chk("fault", 1, st.reset_request_fault);
            chk("mode early", 0, rmode);
            for (n = 0; rmode !== 1'h1 && n < 12000; n++) @(negedge ref_clk_i);
            chk("mode delay", 1, n > d - 8 && n < d + 8);
            chk("host held", 0, hrst_n);
            req = 1'h0;
            repeat (12) @(negedge ref_clk_i);
            chk("host released", 1, hrst_n);
            chk("mode released", 0, rmode);
            pulse(7'h10);
            chk("fault cleared", 0, st.reset_request_fault);
        end
        $display("done reset request");
    endtask

    // main sequence: reset, then each scenario in turn
    initial begin
        press = 1'h0;
        req = 1'h0;
        pd = 1'h0;
        en = 1'h1;
        cfg = '0;
        cmd = '0;
        rst_n_i = 1'h0;
        mismatches = 0;
        checks = 0;
        cyc = 0;
        wakes = 0;
        repeat (16) @(negedge ref_clk_i);
        rst_n_i = 1'h1;
        chk("run reset", 1, run);
        chk("standby reset", 0, stby);
        chk("host reset idle", 1, hrst_n);
        t_plain();
        t_mask();
        t_glitch();
        t_short();
        t_long();
        t_lock_wake();
        t_reset();
        results();
    end
endmodule // tb
